// ### design/fsd_pkg.sv
package fsd_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register indices
    // ------------------------------------------------------------------
    // Byte address of a register is four times its index.
    localparam int unsigned FSD_ADDR_W = 18;
    localparam logic [15:0] FSD_IDX_KEY0 = 16'h0000;
    localparam logic [15:0] FSD_IDX_KEY1 = 16'h0001;
    localparam logic [15:0] FSD_IDX_KEY2 = 16'h0002;
    localparam logic [15:0] FSD_IDX_KEY3 = 16'h0003;
    localparam logic [15:0] FSD_IDX_KEY_CMD = 16'h0004;
    localparam logic [15:0] FSD_IDX_STATUS = 16'h0005;
    localparam logic [15:0] FSD_IDX_PAGE = 16'h0006;
    localparam logic [15:0] FSD_IDX_OPTIONS = 16'hFF0F;
    localparam logic [15:0] FSD_IDX_WINDOW = 16'hBF0F;

    // ------------------------------------------------------------------
    // Options/security byte layout and codes
    // ------------------------------------------------------------------
    localparam int unsigned FSD_BACKDOOR_KEY_ENABLE_FIELD_MSB = 7;
    localparam int unsigned FSD_BACKDOOR_KEY_ENABLE_FIELD_LSB = 6;
    localparam int unsigned FSD_SPARE_MSB = 5;
    localparam int unsigned FSD_SPARE_LSB = 2;
    localparam int unsigned FSD_SEC_MSB = 1;
    localparam int unsigned FSD_SEC_LSB = 0;
    localparam logic [1:0] FSD_SEC_UNSECURED = 2'h2;
    localparam logic [1:0] FSD_SEC_RECOMMENDED = 2'h1;
    localparam logic [1:0] FSD_BACKDOOR_KEY_ENABLE_FIELD_ENABLED = 2'h2;
    localparam logic [7:0] FSD_COPY_RESET = 8'hFF;
    localparam logic [7:0] FSD_PAGE_RESET = 8'h00;
    localparam logic [7:0] FSD_WINDOW_PAGE = 8'h3F;

    // ------------------------------------------------------------------
    // Flash locations, key rules, status and command bits
    // ------------------------------------------------------------------
    localparam logic [15:0] FSD_FLASH_OPTIONS = 16'hFF0F;
    localparam logic [15:0] FSD_FLASH_KEY_BASE = 16'hFF00;
    localparam logic [15:0] FSD_KEY_BAD_LOW = 16'h0000;
    localparam logic [15:0] FSD_KEY_BAD_HIGH = 16'hFFFF;
    localparam logic [2:0] FSD_KEY_LAST_BYTE = 3'h7;
    localparam int unsigned FSD_CMD_START_BIT = 0;
    localparam int unsigned FSD_ST_SECURED = 0;
    localparam int unsigned FSD_ST_BACKDOOR_KEY_ENABLE_FIELD = 1;
    localparam int unsigned FSD_ST_UNLOCKED = 2;
    localparam int unsigned FSD_ST_LOADED = 3;
    localparam int unsigned FSD_ST_KEY_BUSY = 4;
    localparam int unsigned FSD_ST_KEY_FAIL = 5;

    // ------------------------------------------------------------------
    // Secured access limits
    // ------------------------------------------------------------------
    localparam logic [15:0] FSD_REG_AREA_LOW = 16'h0000;
    localparam logic [15:0] FSD_REG_AREA_HIGH = 16'h03FF;
    localparam logic [7:0] FSD_NVM_ERASE_VERIFY = 8'h01;
    localparam logic [7:0] FSD_NVM_MASS_ERASE = 8'h08;
    localparam logic [7:0] FSD_NVM_KEY_VERIFY = 8'h0C;

    typedef enum logic [2:0] {
        FSD_LOAD_REQ = 3'b000,
        FSD_LOAD_WAIT = 3'b001,
        FSD_READY = 3'b010,
        FSD_KEY_REQ = 3'b011,
        FSD_KEY_WAIT = 3'b100
    } fsd_state_type;

endpackage : fsd_pkg

// ### design/fsd_key_check.sv
`timescale 1ns/10ps
// Compares the eight stored key bytes, arriving one by one, with the key
// software supplied, and refuses any key holding a forbidden word.
module fsd_key_check
    import fsd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Byte stream from the flash
    input wire logic start,
    input wire logic byte_valid,
    input wire logic [2:0] byte_index,
    input wire logic [7:0] ref_byte,
    input wire logic [63:0] user_key,
    // Result
    output logic done,
    output logic match
);

    logic mismatch;
    logic bad_word;
    logic [7:0] high_byte;
    logic [7:0] user_byte;
    logic [15:0] word_now;

    // Byte 0 is the high byte of the first key word.
    assign user_byte = user_key[8'(63 - 8 * byte_index) -: 8];
    assign word_now = {high_byte, ref_byte};

    // Mismatch and forbidden words accumulate over one pass.
    always_ff @(posedge ref_clk) begin
        if (rst || start) begin
            mismatch <= 1'b0;
            bad_word <= 1'b0;
            high_byte <= 8'h00;
        end else if (byte_valid) begin
            if (ref_byte != user_byte) begin
                mismatch <= 1'b1;
            end
            if (!byte_index[0]) begin
                high_byte <= ref_byte;
            end else if (word_now == FSD_KEY_BAD_LOW ||
                         word_now == FSD_KEY_BAD_HIGH) begin
                bad_word <= 1'b1;
            end
        end
    end

    // Result is given on the edge after the last byte.
    always_ff @(posedge ref_clk) begin
        if (rst || start) begin
            done <= 1'b0;
            match <= 1'b0;
        end else begin
            done <= byte_valid && byte_index == FSD_KEY_LAST_BYTE;
            match <= byte_valid && byte_index == FSD_KEY_LAST_BYTE &&
                     !mismatch && ref_byte == user_byte &&
                     !bad_word && word_now != FSD_KEY_BAD_LOW &&
                     word_now != FSD_KEY_BAD_HIGH;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_bad_key;
        byte_valid && byte_index == FSD_KEY_LAST_BYTE &&
        (word_now == FSD_KEY_BAD_LOW || word_now == FSD_KEY_BAD_HIGH)
        |=> done && !match;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("Forbidden key word was accepted.");

endmodule : fsd_key_check

// ### design/fsd_security.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - Every reset loads the options byte from flash into the copy register.
// - The options byte is also readable at 0xBF0F when page select is 0x3F.
// - Byte holds key enable in 7:6, spare bits 5:2, security in 1:0.
// - Only security code 10 unsecures; 00, 01 and 11 keep it secured.
// - Backdoor key access is enabled only by enable code 10.
// - Security persists over resets since it lives in flash.
// - While secured only a small set of memory commands is accepted.
// - While secured the debug unit cannot read internal memory.
// - Secured special mode confines debug hardware commands to registers.
// - Secured normal mode disables debug entirely, and tracing too.
// - Reprogramming to unsecured takes effect only at the next reset.
// - Key words of 0x0000 or 0xFFFF never match.
module fsd_security
    import fsd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [FSD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash array read port
    output logic flash_rd_req,
    output logic [15:0] flash_rd_addr,
    input wire logic flash_rd_valid,
    input wire logic [7:0] flash_rd_data,
    // Operating mode pin, high in special single chip mode
    input wire logic special_mode_pin,
    // Single wire debug unit access requests
    input wire logic dbg_req,
    input wire logic dbg_hw_cmd,
    input wire logic [15:0] dbg_addr,
    output logic dbg_grant,
    output logic dbg_refuse,
    // Memory command gate
    input wire logic nvm_cmd_valid,
    input wire logic [7:0] nvm_cmd,
    output logic nvm_cmd_accept,
    output logic nvm_cmd_reject,
    // Security indications
    output logic secured,
    output logic backdoor_enabled,
    output logic trace_enable,
    output logic load_done
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic sec_locked(input logic [7:0] b);
        return b[FSD_SEC_MSB:FSD_SEC_LSB] != FSD_SEC_UNSECURED;
    endfunction : sec_locked

    function automatic logic in_reg_area(input logic [15:0] a);
        return a >= FSD_REG_AREA_LOW && a <= FSD_REG_AREA_HIGH;
    endfunction : in_reg_area

    function automatic logic nvm_allowed(input logic [7:0] c);
        return c == FSD_NVM_ERASE_VERIFY || c == FSD_NVM_MASS_ERASE ||
               c == FSD_NVM_KEY_VERIFY;
    endfunction : nvm_allowed

    fsd_state_type state;
    logic [7:0] security_copy_register;
    logic [7:0] program_page_select;
    logic [15:0] key_word [4];
    logic [2:0] key_byte;
    logic key_start;
    logic key_done;
    logic key_match;
    logic key_fail;
    logic key_unlocked;
    logic special_meta;
    logic special_mode;
    logic secured_eff;
    logic [15:0] reg_index;
    logic setup_phase;
    logic write_taken;
    logic [31:0] next_prdata;
    logic next_slverr;

    // ------------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------------
    // The pin is asynchronous; only the second stage is used anywhere.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            special_meta <= 1'b0;
            special_mode <= 1'b0;
        end else begin
            special_meta <= special_mode_pin;
            special_mode <= special_meta;
        end
    end

    // ------------------------------------------------------------------
    // Reset load and key sequencer
    // ------------------------------------------------------------------
    // The flash port is shared; a key pass can only start once loaded.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= FSD_LOAD_REQ;
            key_byte <= 3'h0;
        end else begin
            unique case (state)
                FSD_LOAD_REQ: begin
                    state <= FSD_LOAD_WAIT;
                end
                FSD_LOAD_WAIT: begin
                    if (flash_rd_valid) begin
                        state <= FSD_READY;
                    end
                end
                FSD_READY: begin
                    if (key_start) begin
                        key_byte <= 3'h0;
                        state <= FSD_KEY_REQ;
                    end
                end
                FSD_KEY_REQ: begin
                    state <= FSD_KEY_WAIT;
                end
                FSD_KEY_WAIT: begin
                    if (flash_rd_valid) begin
                        key_byte <= key_byte + 3'h1;
                        state <= (key_byte == FSD_KEY_LAST_BYTE) ?
                                 FSD_READY : FSD_KEY_REQ;
                    end
                end
                default: state <= FSD_LOAD_REQ;
            endcase
        end
    end

    // One read request per request state, address fixed meanwhile.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_rd_req <= 1'b0;
            flash_rd_addr <= FSD_FLASH_OPTIONS;
        end else begin
            flash_rd_req <= state == FSD_LOAD_REQ || state == FSD_KEY_REQ;
            if (state == FSD_LOAD_REQ) begin
                flash_rd_addr <= FSD_FLASH_OPTIONS;
            end else if (state == FSD_KEY_REQ) begin
                flash_rd_addr <= FSD_FLASH_KEY_BASE | {13'h0000, key_byte};
            end
        end
    end

    // The copy is written only by the load, so later flash programming
    // cannot change security before the next reset.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            security_copy_register <= FSD_COPY_RESET;
            load_done <= 1'b0;
        end else if (state == FSD_LOAD_WAIT && flash_rd_valid) begin
            security_copy_register <= flash_rd_data;
            load_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Decoded indications
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            secured <= 1'b1;
            backdoor_enabled <= 1'b0;
        end else begin
            secured <= !load_done || sec_locked(security_copy_register);
            backdoor_enabled <= load_done &&
                security_copy_register[FSD_BACKDOOR_KEY_ENABLE_FIELD_MSB:FSD_BACKDOOR_KEY_ENABLE_FIELD_LSB] ==
                FSD_BACKDOOR_KEY_ENABLE_FIELD_ENABLED;
        end
    end

    // A good backdoor key lifts security until reset or the next failing key pass, in normal mode only.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            key_unlocked <= 1'b0;
            key_fail <= 1'b0;
        end else if (key_done) begin
            key_unlocked <= key_match && backdoor_enabled && !special_mode;
            key_fail <= !(key_match && backdoor_enabled && !special_mode);
        end else if (key_start) begin
            key_fail <= 1'b0;
        end
    end

    assign secured_eff = secured && !key_unlocked;

    fsd_key_check u_key_check (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(key_start),
        .byte_valid(state == FSD_KEY_WAIT && flash_rd_valid),
        .byte_index(key_byte),
        .ref_byte(flash_rd_data),
        .user_key({key_word[0], key_word[1], key_word[2], key_word[3]}),
        .done(key_done),
        .match(key_match)
    );

    // ------------------------------------------------------------------
    // Access gating
    // ------------------------------------------------------------------
    // Firmware commands read memory, so any secured state refuses them.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dbg_grant <= 1'b0;
            dbg_refuse <= 1'b0;
        end else if (!dbg_req) begin
            dbg_grant <= 1'b0;
            dbg_refuse <= 1'b0;
        end else if (!secured_eff) begin
            dbg_grant <= 1'b1;
            dbg_refuse <= 1'b0;
        end else begin
            dbg_grant <= special_mode && dbg_hw_cmd &&
                         in_reg_area(dbg_addr);
            dbg_refuse <= !(special_mode && dbg_hw_cmd &&
                            in_reg_area(dbg_addr));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nvm_cmd_accept <= 1'b0;
            nvm_cmd_reject <= 1'b0;
        end else begin
            nvm_cmd_accept <= nvm_cmd_valid &&
                              (!secured_eff || nvm_allowed(nvm_cmd));
            nvm_cmd_reject <= nvm_cmd_valid && secured_eff &&
                              !nvm_allowed(nvm_cmd);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trace_enable <= 1'b0;
        end else begin
            trace_enable <= !secured_eff;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign reg_index = paddr[17:2];
    assign setup_phase = psel && !penable;
    assign write_taken = psel && penable && pready && pwrite;
    assign key_start = write_taken && reg_index == FSD_IDX_KEY_CMD &&
                       pwdata[FSD_CMD_START_BIT] && state == FSD_READY;

    // Read data and error are formed in the setup cycle.
    always_comb begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        unique case (reg_index)
            FSD_IDX_KEY0: next_prdata = {16'h0000, key_word[0]};
            FSD_IDX_KEY1: next_prdata = {16'h0000, key_word[1]};
            FSD_IDX_KEY2: next_prdata = {16'h0000, key_word[2]};
            FSD_IDX_KEY3: next_prdata = {16'h0000, key_word[3]};
            FSD_IDX_KEY_CMD: next_prdata = 32'h00000000;
            FSD_IDX_STATUS: begin
                next_prdata[FSD_ST_SECURED] = secured_eff;
                next_prdata[FSD_ST_BACKDOOR_KEY_ENABLE_FIELD] = backdoor_enabled;
                next_prdata[FSD_ST_UNLOCKED] = key_unlocked;
                next_prdata[FSD_ST_LOADED] = load_done;
                next_prdata[FSD_ST_KEY_BUSY] = state != FSD_READY;
                next_prdata[FSD_ST_KEY_FAIL] = key_fail;
            end
            FSD_IDX_PAGE: next_prdata = {24'h000000, program_page_select};
            FSD_IDX_OPTIONS: begin
                next_prdata = {24'h000000, security_copy_register};
            end
            FSD_IDX_WINDOW: begin
                if (program_page_select == FSD_WINDOW_PAGE) begin
                    next_prdata = {24'h000000, security_copy_register};
                end else begin
                    next_slverr = 1'b1;
                end
            end
            default: next_slverr = 1'b1;
        endcase
    end

    // Every transfer has exactly one access cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && next_slverr;
            if (setup_phase && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            program_page_select <= FSD_PAGE_RESET;
            key_word <= '{4{16'h0000}};
        end else if (write_taken) begin
            if (reg_index == FSD_IDX_PAGE) begin
                program_page_select <= pwdata[7:0];
            end
            if (reg_index <= FSD_IDX_KEY3 && state == FSD_READY) begin
                key_word[reg_index[1:0]] <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_load_secured;
        !load_done |=> secured;
    endproperty
    a_load_secured: assert property (p_load_secured)
        else $error("Part shown unsecured before the load finished.");

    property p_unsec_code;
        load_done && security_copy_register[1:0] == 2'b10 |=> !secured;
    endproperty
    a_unsec_code: assert property (p_unsec_code)
        else $error("Unsecured code did not unsecure the part.");

    property p_sec_code;
        security_copy_register[1:0] != 2'b10 |=> secured;
    endproperty
    a_sec_code: assert property (p_sec_code)
        else $error("Secured code left the part unsecured.");

    property p_backdoor_key_enable_field_code;
        load_done |=> backdoor_enabled ==
            ($past(security_copy_register[7:6]) == 2'b10);
    endproperty
    a_backdoor_key_enable_field_code: assert property (p_backdoor_key_enable_field_code)
        else $error("Backdoor enable decode is wrong.");

    property p_copy_fixed;
        load_done |=> $stable(security_copy_register) && load_done;
    endproperty
    a_copy_fixed: assert property (p_copy_fixed)
        else $error("Security copy changed after the load.");

    property p_load_addr;
        state == FSD_LOAD_REQ |=> flash_rd_req &&
            flash_rd_addr == 16'hFF0F;
    endproperty
    a_load_addr: assert property (p_load_addr)
        else $error("Reset load read the wrong flash location.");

    property p_normal_refuse;
        dbg_req && secured_eff && !special_mode |=> dbg_refuse && !dbg_grant;
    endproperty
    a_normal_refuse: assert property (p_normal_refuse)
        else $error("Debug access granted in secured normal mode.");

    property p_special_area;
        dbg_req && secured_eff && !in_reg_area(dbg_addr) |=> dbg_refuse;
    endproperty
    a_special_area: assert property (p_special_area)
        else $error("Secured debug access outside registers granted.");

    property p_nvm_gate;
        nvm_cmd_valid && secured_eff && !nvm_allowed(nvm_cmd)
        |=> nvm_cmd_reject && !nvm_cmd_accept;
    endproperty
    a_nvm_gate: assert property (p_nvm_gate)
        else $error("Restricted memory command accepted while secured.");

    property p_trace_off;
        secured_eff |=> !trace_enable;
    endproperty
    a_trace_off: assert property (p_trace_off)
        else $error("Tracing enabled while secured.");

    property p_window_read;
        setup_phase && !pwrite && reg_index == 16'hBF0F &&
        program_page_select == 8'h3F
        |=> pready && prdata == {24'h000000, security_copy_register};
    endproperty
    a_window_read: assert property (p_window_read)
        else $error("Paged window did not return the options byte.");

endmodule : fsd_security

// ### testbench/fsd_flash_model.sv
`timescale 1ns/10ps
// Flash array stand-in: answers each read after one or four cycles.
module fsd_flash_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Read port
    input wire logic flash_rd_req,
    input wire logic [15:0] flash_rd_addr,
    output logic flash_rd_valid,
    output logic [7:0] flash_rd_data,
    // Stored options byte and answer speed
    input wire logic [7:0] opt,
    input wire logic slow
);
    logic busy;
    logic [1:0] wait_cnt;
    logic [15:0] addr;

    // The data bus toggles when idle so that a stale byte never looks valid.
    always_ff @(posedge ref_clk) begin
        flash_rd_valid <= 1'b0;
        flash_rd_data <= ~flash_rd_data;
        if (rst) begin
            busy <= 1'b0;
            flash_rd_data <= 8'h5A;
        end else if (flash_rd_req) begin
            busy <= 1'b1;
            wait_cnt <= slow ? 2'h3 : 2'h0;
            addr <= flash_rd_addr;
        end else if (busy && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else if (busy) begin
            busy <= 1'b0;
            flash_rd_valid <= 1'b1;
            // Stored contents persist until the bench reprograms them.
            flash_rd_data <= (addr == 16'hFF0F) ? opt : addr[7:0];
        end
    end
endmodule : fsd_flash_model

// ### testbench/fsd_security_test.sv
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    $display("BAD %s exp %h seen %h", what, exp, got); fail_count++; end end
module fsd_security_test
    import fsd_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic ref_clk, rst, psel, penable, pwrite, special_mode_pin, slow;
    logic dbg_req, dbg_hw_cmd, nvm_cmd_valid, pready, pslverr, err;
    logic flash_rd_req, flash_rd_valid, dbg_grant, dbg_refuse, sec, ken;
    logic nvm_cmd_accept, nvm_cmd_reject, secured, backdoor_enabled;
    logic trace_enable, load_done, unl;
    logic [FSD_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] dbg_addr, flash_rd_addr;
    logic [7:0] nvm_cmd, opt, flash_rd_data;
    int fail_count = 0;
    int compares = 0;
    // Secured images use the recommended code 01 where they can.
    logic [7:0] opts [8] = '{8'h02, 8'h00, 8'h81, 8'h03, 8'h82, 8'h41,
        8'hC2, 8'hBE};

    fsd_security dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .flash_rd_req, .flash_rd_addr,
        .flash_rd_valid, .flash_rd_data, .special_mode_pin, .dbg_req,
        .dbg_hw_cmd, .dbg_addr, .dbg_grant, .dbg_refuse, .nvm_cmd_valid,
        .nvm_cmd, .nvm_cmd_accept, .nvm_cmd_reject, .secured,
        .backdoor_enabled, .trace_enable, .load_done);
    fsd_flash_model flash (.ref_clk, .rst, .flash_rd_req, .flash_rd_addr,
        .flash_rd_valid, .flash_rd_data, .opt, .slow);

    // Free-running 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    // One APB transfer; waits for pready rather than assuming a latency.
    task automatic apb(input logic wr, input logic [15:0] idx,
        input logic [31:0] wd, output logic [31:0] rdat, output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // A debug request and a memory command in the same cycle.
    task automatic gate(input logic hw, input logic [15:0] a,
        input logic [7:0] c, input logic eg, input logic ea);
        @(posedge ref_clk);
        dbg_req <= 1'b1;
        dbg_hw_cmd <= hw;
        dbg_addr <= a;
        nvm_cmd_valid <= 1'b1;
        nvm_cmd <= c;
        @(posedge ref_clk);
        dbg_req <= 1'b0;
        nvm_cmd_valid <= 1'b0;
        @(posedge ref_clk);
        `CHK("grant", eg, dbg_grant)
        `CHK("refuse", !eg, dbg_refuse)
        `CHK("accept", ea, nvm_cmd_accept)
        `CHK("reject", !ea, nvm_cmd_reject)
    endtask : gate

    // Reset for five cycles; a slow flash lets the pre-load state be seen.
    task automatic boot(input logic [7:0] o, input logic m);
        int n;
        @(posedge ref_clk);
        rst <= 1'b1;
        opt <= o;
        special_mode_pin <= m;
        slow <= m;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        if (m) `CHK("early secured", 1'b1, secured)
        n = 0;
        while (load_done !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        if (load_done !== 1'b1) begin
            fail_count++;
            test_done();
        end
        repeat (2) @(posedge ref_clk);
    endtask : boot

    // ------------------------------------------------------------------
    // Main sequence: every code of both fields, and both modes
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; special_mode_pin = 1'b0; slow = 1'b0;
        dbg_req = 1'b0; dbg_hw_cmd = 1'b0; dbg_addr = '0;
        nvm_cmd_valid = 1'b0; nvm_cmd = '0; opt = '0;
        for (int i = 0; i < 8; i++) begin
            boot(opts[i], i[0]);
            sec = opts[i][1:0] != FSD_SEC_UNSECURED;
            ken = opts[i][7:6] == FSD_BACKDOOR_KEY_ENABLE_FIELD_ENABLED;
            `CHK("secured", sec, secured)
            `CHK("backdoor_key_enable_field", ken, backdoor_enabled)
            `CHK("trace", !sec, trace_enable)
            apb(1'b0, FSD_IDX_OPTIONS, 32'h0, rd, err);
            `CHK("options", {24'h0, opts[i]}, rd)
            apb(1'b0, FSD_IDX_STATUS, 32'h0, rd, err);
            `CHK("status", {2'b10, ken, sec}, rd[3:0])
            apb(1'b1, FSD_IDX_PAGE, 32'h3F, rd, err);
            apb(1'b0, FSD_IDX_WINDOW, 32'h0, rd, err);
            `CHK("window", {1'b0, 24'h0, opts[i]}, {err, rd})
            apb(1'b1, FSD_IDX_PAGE, 32'h0, rd, err);
            apb(1'b0, FSD_IDX_WINDOW, 32'h0, rd, err);
            `CHK("window off page", 1'b1, err)
            apb(1'b0, 16'h0100, 32'h0, rd, err);
            `CHK("unmapped", 1'b1, err)
            gate(1'b0, 16'h0100, 8'h01, !sec, 1'b1);
            gate(1'b1, 16'h03FF, 8'h08, !sec || i[0], 1'b1);
            gate(1'b1, 16'h0400, 8'h0C, !sec, 1'b1);
            gate(1'b1, 16'h0000, 8'h02, !sec || i[0], !sec);
            // Reprogrammed flash must not change state before a reset.
            opt <= opts[i] ^ 8'h03;
            repeat (3) @(posedge ref_clk);
            `CHK("held", sec, secured)
            // Backdoor pass with the key the flash stand-in holds.
            unl = ken && !i[0];
            for (int k = 0; k < 4; k++)
                apb(1'b1, 16'(k), {16'h0, 8'(2 * k), 8'(2 * k + 1)}, rd, err);
            apb(1'b1, FSD_IDX_KEY_CMD, 32'h1, rd, err);
            repeat (80) @(posedge ref_clk);
            apb(1'b0, FSD_IDX_STATUS, 32'h0, rd, err);
            `CHK("key", {!unl, 1'b0, unl}, {rd[5:4], rd[2]})
            `CHK("trace key", !sec || unl, trace_enable)
        end
        test_done();
    end
endmodule : fsd_security_test
